// File: core/pia_irq_map.vh
`ifndef PIA_IRQ_MAP_VH
`define PIA_IRQ_MAP_VH
// =====================================================================
// register addresses
// =====================================================================
`define PIA_ADDR_FALL_WR    6'h10
`define PIA_ADDR_FALL_SET   6'h11
`define PIA_ADDR_FALL_CLR   6'h12
`define PIA_ADDR_LIVE       6'h13
`define PIA_ADDR_LATCH      6'h14
`define PIA_ADDR_DEBUG      6'h15
`define PIA_ADDR_SCR_WR     6'h16
`define PIA_ADDR_SCR_SET    6'h17
`define PIA_ADDR_SCR_CLR    6'h18
`define PIA_ADDR_ACC_WR     6'h19
`define PIA_ADDR_ACC_SET    6'h1A
`define PIA_ADDR_ACC_CLR    6'h1B
// =====================================================================
// interrupt source bit positions
// =====================================================================
`define PIA_SRC_HOST_DISC   0
`define PIA_SRC_VBUS_OK     1
`define PIA_SRC_SESS_OK     2
`define PIA_SRC_SESS_OVER   3
`define PIA_SRC_ID_GND      4
`define PIA_SRC_COUNT       5
// =====================================================================
// accessory control bit positions
// =====================================================================
`define PIA_ACC_KIT_POWER   0
`define PIA_ACC_ID_PULLDOWN 1
`define PIA_ACC_UART_TX     2
`define PIA_ACC_UART_RX     3
`define PIA_ACC_LEFT_AUDIO  4
`define PIA_ACC_RIGHT_AUDIO 5
`define PIA_ACC_MIC_AUDIO   6
`define PIA_ACC_DATA2_FLOAT 7
// =====================================================================
// reset values
// =====================================================================
`define PIA_RST_FALL_UPPER  2'h3
`define PIA_RST_SCRATCH     8'h00
`define PIA_RST_ACCESSORY   8'h00
`define PIA_RST_LATCH       5'h00
`define PIA_RST_RDATA       8'h00
`endif

// File: core/pia_regs.v
`timescale 1ns/1ps
`include "pia_irq_map.vh"

module pia_regs
#(
    parameter SYNC_STAGES = 2
)
(
    input  wire       clk_i,
    input  wire       reset_n_i,
    // register access from the link-side interface logic
    input  wire [5:0] reg_addr_i,
    input  wire       reg_wr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       reg_rd_i,
    output reg  [7:0] reg_rdata_o,
    output reg        reg_rvalid_o,
    // neighbouring enable registers kept elsewhere
    input  wire [4:0] rise_enable_i,
    input  wire [2:0] fall_enable_low_i,
    output wire [4:0] fall_enable_o,
    // interface control bits kept elsewhere
    input  wire       accessory_mode_bit_i,
    input  wire       serial_mode_i,
    input  wire       clock_keep_alive_i,
    output wire       interface_clock_output_en_o,
    // comparator and line levels from the analog side
    input  wire       host_disconnect_i,
    input  wire       vbus_valid_i,
    input  wire       session_ok_level_i,
    input  wire       session_over_level_i,
    input  wire       id_grounded_level_i,
    input  wire [1:0] line_state_i,
    input  wire       dp_level_i,
    // interface data pins in accessory mode
    input  wire       data0_i,
    output reg        data1_o,
    output reg        data1_oe_o,
    output reg        data2_o,
    output reg        data2_oe_o,
    // switch and driver controls toward the analog side
    output reg        dm_uart_o,
    output reg        dm_uart_oe_o,
    output reg        id_pulldown_drive_o,
    output reg        left_audio_switch_o,
    output reg        right_audio_switch_o,
    output reg        se_rx_disable_o,
    output wire [4:0] irq_event_o
);

    // =================================================================
    // input synchronisers
    // =================================================================
    localparam NSYNC = 9;

    wire [NSYNC-1:0] async_in;
    wire [NSYNC-1:0] sync_out;

    assign async_in = {data0_i, dp_level_i, line_state_i,
                       id_grounded_level_i, session_over_level_i,
                       session_ok_level_i, vbus_valid_i,
                       host_disconnect_i};

    // two flops per bit; first stage only feeds the second
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1)
        begin : g_sync
            reg meta_r;
            reg stable_r;
            always @(posedge clk_i)
            begin
                if (!reset_n_i)
                begin
                    meta_r   <= 1'b0;
                    stable_r <= 1'b0;
                end
                else
                begin
                    meta_r   <= async_in[gi];
                    stable_r <= meta_r;
                end
            end
            assign sync_out[gi] = stable_r;
        end
    endgenerate

    wire [4:0] src_level;
    wire [1:0] line_level;
    wire       dp_sync;
    wire       data0_sync;

    assign src_level  = sync_out[4:0];
    assign line_level = sync_out[6:5];
    assign dp_sync    = sync_out[7];
    assign data0_sync = sync_out[8];

    // =================================================================
    // address decode
    // =================================================================
    wire wr_fall;
    wire set_fall;
    wire clr_fall;
    wire wr_scr;
    wire set_scr;
    wire clr_scr;
    wire wr_acc;
    wire set_acc;
    wire clr_acc;
    wire rd_latch;

    assign wr_fall  = reg_wr_i && (reg_addr_i == `PIA_ADDR_FALL_WR);
    assign set_fall = reg_wr_i && (reg_addr_i == `PIA_ADDR_FALL_SET);
    assign clr_fall = reg_wr_i && (reg_addr_i == `PIA_ADDR_FALL_CLR);
    assign wr_scr   = reg_wr_i && (reg_addr_i == `PIA_ADDR_SCR_WR);
    assign set_scr  = reg_wr_i && (reg_addr_i == `PIA_ADDR_SCR_SET);
    assign clr_scr  = reg_wr_i && (reg_addr_i == `PIA_ADDR_SCR_CLR);
    assign wr_acc   = reg_wr_i && (reg_addr_i == `PIA_ADDR_ACC_WR);
    assign set_acc  = reg_wr_i && (reg_addr_i == `PIA_ADDR_ACC_SET);
    assign clr_acc  = reg_wr_i && (reg_addr_i == `PIA_ADDR_ACC_CLR);
    // latch has no write path; only a read clears it
    assign rd_latch = reg_rd_i && (reg_addr_i == `PIA_ADDR_LATCH);

    // =================================================================
    // upper falling enables (session over, id grounded)
    // =================================================================
    reg  [1:0] fall_upper_r;
    reg  [1:0] fall_upper_nxt;
    wire [1:0] wbits_fall;

    assign wbits_fall = reg_wdata_i[`PIA_SRC_ID_GND:`PIA_SRC_SESS_OVER];

    // write, set and clear forms of the same two bits
    always @*
    begin
        fall_upper_nxt = fall_upper_r;
        if (wr_fall)
            fall_upper_nxt = wbits_fall;
        else if (set_fall)
            fall_upper_nxt = fall_upper_r | wbits_fall;
        else if (clr_fall)
            fall_upper_nxt = fall_upper_r & ~wbits_fall;
    end

    always @(posedge clk_i)
    begin
        if (!reset_n_i)
            fall_upper_r <= `PIA_RST_FALL_UPPER;
        else
            fall_upper_r <= fall_upper_nxt;
    end

    assign fall_enable_o = {fall_upper_r, fall_enable_low_i};

    // =================================================================
    // edge detection and event latch
    // =================================================================
    reg  [4:0] src_prev_r;
    reg  [4:0] latch_r;
    reg  [4:0] latch_nxt;
    wire [4:0] edge_hit;

    // enabled rise or fall per source
    generate
        for (gi = 0; gi < `PIA_SRC_COUNT; gi = gi + 1)
        begin : g_edge
            assign edge_hit[gi] =
                (rise_enable_i[gi] && src_level[gi] && !src_prev_r[gi]) ||
                (fall_enable_o[gi] && !src_level[gi] && src_prev_r[gi]);
        end
    endgenerate
    // falling arm of the two upper enables above

    always @(posedge clk_i)
    begin
        if (!reset_n_i)
            src_prev_r <= 5'h00;
        else
            src_prev_r <= src_level;
    end

    // read clears, but a new edge in that cycle still sets
    always @*
    begin
        latch_nxt = latch_r;
        if (rd_latch)
            latch_nxt = 5'h00;
        latch_nxt = latch_nxt | edge_hit;
    end

    always @(posedge clk_i)
    begin
        if (!reset_n_i)
            latch_r <= `PIA_RST_LATCH;
        else
            latch_r <= latch_nxt;
    end

    assign irq_event_o = edge_hit;

    // =================================================================
    // live status view
    // =================================================================
    wire [4:0] live_view;
    wire       vbus_masked;
    wire       over_masked;

    assign vbus_masked = rise_enable_i[`PIA_SRC_VBUS_OK] &&
                         fall_enable_o[`PIA_SRC_VBUS_OK];
    assign over_masked = rise_enable_i[`PIA_SRC_SESS_OVER] &&
                         fall_enable_o[`PIA_SRC_SESS_OVER];

    // host detach and id grounded pass straight through
    assign live_view[`PIA_SRC_HOST_DISC] =
        src_level[`PIA_SRC_HOST_DISC];
    assign live_view[`PIA_SRC_VBUS_OK] =
        src_level[`PIA_SRC_VBUS_OK] && !vbus_masked;
    assign live_view[`PIA_SRC_SESS_OK] =
        src_level[`PIA_SRC_SESS_OK];
    assign live_view[`PIA_SRC_SESS_OVER] =
        src_level[`PIA_SRC_SESS_OVER] && !over_masked;
    assign live_view[`PIA_SRC_ID_GND] =
        src_level[`PIA_SRC_ID_GND];

    // =================================================================
    // scratch byte
    // =================================================================
    reg [7:0] scratch_r;
    reg [7:0] scratch_nxt;

    // storage only, steers nothing
    always @*
    begin
        scratch_nxt = scratch_r;
        if (wr_scr)
            scratch_nxt = reg_wdata_i;
        else if (set_scr)
            scratch_nxt = scratch_r | reg_wdata_i;
        else if (clr_scr)
            scratch_nxt = scratch_r & ~reg_wdata_i;
    end

    always @(posedge clk_i)
    begin
        if (!reset_n_i)
            scratch_r <= `PIA_RST_SCRATCH;
        else
            scratch_r <= scratch_nxt;
    end

    // =================================================================
    // accessory switch control
    // =================================================================
    reg [7:0] acc_r;
    reg [7:0] acc_nxt;

    // bit 0 is never stored so it always reads zero
    always @*
    begin
        acc_nxt = acc_r;
        if (wr_acc)
            acc_nxt = reg_wdata_i;
        else if (set_acc)
            acc_nxt = acc_r | reg_wdata_i;
        else if (clr_acc)
            acc_nxt = acc_r & ~reg_wdata_i;
        acc_nxt[`PIA_ACC_KIT_POWER] = 1'b0;
    end

    always @(posedge clk_i)
    begin
        if (!reset_n_i)
            acc_r <= `PIA_RST_ACCESSORY;
        else
            acc_r <= acc_nxt;
    end

    // =================================================================
    // read data path
    // =================================================================
    reg [7:0] rd_mux;

    // live values sampled in the read cycle
    always @*
    begin
        rd_mux = 8'h00;
        case (reg_addr_i)
            `PIA_ADDR_FALL_WR,
            `PIA_ADDR_FALL_SET,
            `PIA_ADDR_FALL_CLR:
                rd_mux = {3'h0, fall_enable_o};
            `PIA_ADDR_LIVE:
                rd_mux = {3'h0, live_view};
            `PIA_ADDR_LATCH:
                rd_mux = {3'h0, latch_r};
            `PIA_ADDR_DEBUG:
                rd_mux = {6'h00, line_level};
            `PIA_ADDR_SCR_WR,
            `PIA_ADDR_SCR_SET,
            `PIA_ADDR_SCR_CLR:
                rd_mux = scratch_r;
            `PIA_ADDR_ACC_WR,
            `PIA_ADDR_ACC_SET,
            `PIA_ADDR_ACC_CLR:
                rd_mux = acc_r;
            default:
                rd_mux = 8'h00;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            reg_rdata_o  <= `PIA_RST_RDATA;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
                reg_rdata_o <= rd_mux;
        end
    end

    // =================================================================
    // accessory pin routing
    // =================================================================
    wire acc_on;
    wire rx_route;
    wire tx_route;
    wire any_audio;

    // link sets routes before entering accessory mode
    assign acc_on    = accessory_mode_bit_i;
    assign rx_route  = acc_r[`PIA_ACC_UART_RX];
    assign tx_route  = acc_r[`PIA_ACC_UART_TX];
    assign any_audio = acc_r[`PIA_ACC_LEFT_AUDIO] |
                       acc_r[`PIA_ACC_RIGHT_AUDIO] |
                       acc_r[`PIA_ACC_MIC_AUDIO];

    // data lines 1 and 2 plus dm driver, all registered
    always @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            data1_o      <= 1'b1;
            data1_oe_o   <= 1'b0;
            data2_o      <= 1'b0;
            data2_oe_o   <= 1'b0;
            dm_uart_o    <= 1'b0;
            dm_uart_oe_o <= 1'b0;
        end
        else
        begin
            data1_oe_o   <= acc_on;
            data1_o      <= rx_route ? dp_sync : 1'b1;
            data2_o      <= 1'b0;
            data2_oe_o   <= acc_on &&
                            !acc_r[`PIA_ACC_DATA2_FLOAT];
            dm_uart_o    <= data0_sync;
            dm_uart_oe_o <= acc_on && tx_route;
        end
    end

    // analog switch controls; closed switches also carry uart levels
    always @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            id_pulldown_drive_o  <= 1'b0;
            left_audio_switch_o  <= 1'b0;
            right_audio_switch_o <= 1'b0;
            se_rx_disable_o      <= 1'b0;
        end
        else
        begin
            id_pulldown_drive_o  <= acc_r[`PIA_ACC_ID_PULLDOWN];
            left_audio_switch_o  <= acc_r[`PIA_ACC_LEFT_AUDIO];
            right_audio_switch_o <= acc_r[`PIA_ACC_RIGHT_AUDIO] |
                                    acc_r[`PIA_ACC_MIC_AUDIO];
            // switches stay closed in uart use too
            se_rx_disable_o      <= any_audio;
        end
    end
    // no interlock between routes and audio switches

    // =================================================================
    // interface clock keep-alive
    // =================================================================
    // clock stops in serial or accessory mode unless kept alive
    assign interface_clock_output_en_o =
        !(serial_mode_i || acc_on) || clock_keep_alive_i;

endmodule

// File: test/pia_link_model.sv
`timescale 1ns/1ps
// =====================================================================
// link side register master
// =====================================================================
module pia_link_model
(
    input  wire       clk_i,
    input  wire [7:0] rdata_i,
    input  wire       rvalid_i,
    output reg  [5:0] addr_o,
    output reg        wr_o,
    output reg  [7:0] wdata_o,
    output reg        rd_o,
    output reg        acc_mode_o
);
    // bus idle from time zero
    initial
    begin
        addr_o = 6'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
        acc_mode_o = 1'b0;
    end
    // one-cycle write strobe
    task wr_reg(input [5:0] a, input [7:0] d);
    begin
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    end
    endtask
    // one-cycle read strobe, bounded wait for the answer
    task rd_reg(input [5:0] a, output [7:0] d, output ok);
        integer n;
    begin
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        for (n = 0; n < 3 && !ok; n = n + 1)
        begin
            #1;
            if (rvalid_i === 1'b1)
                ok = 1'b1;
            else
                @(posedge clk_i);
        end
        d = rdata_i;
    end
    endtask
    // audio off, routes programmed, only then accessory mode
    task enter_uart(input [7:0] routes);
    begin
        wr_reg(6'h1B, 8'h70);
        wr_reg(6'h1A, routes);
        @(posedge clk_i);
        acc_mode_o <= 1'b1;
    end
    endtask
endmodule

// File: test/pia_regs_asserts.sv
`timescale 1ns/1ps
// =====================================================================
// port checker for the register block
// =====================================================================
module pia_regs_chk
(
    input wire       clk_i,
    input wire       reset_n_i,
    input wire [5:0] reg_addr_i,
    input wire       reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire       reg_rvalid_o,
    input wire [2:0] fall_enable_low_i,
    input wire [4:0] fall_enable_o,
    input wire       accessory_mode_bit_i,
    input wire       serial_mode_i,
    input wire       clock_keep_alive_i,
    input wire       interface_clock_output_en_o,
    input wire       data1_oe_o,
    input wire       data2_o,
    input wire       data2_oe_o,
    input wire       dm_uart_oe_o,
    input wire       left_audio_switch_o,
    input wire       right_audio_switch_o,
    input wire       se_rx_disable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // read handshake and data holding
    a_read_answered: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read without answer");
    a_answer_caused: assert property (
        reg_rvalid_o |-> $past(reg_rd_i))
        else $error("answer without read");
    a_rdata_holds: assert property (
        !reg_rvalid_o |-> $stable(reg_rdata_o))
        else $error("read data moved between reads");
    // reserved bits of the status group and accessory bit 0
    a_live_upper: assert property (reg_rvalid_o &&
        $past(reg_addr_i) == 6'h13 |-> reg_rdata_o[7:5] == 3'h0)
        else $error("live status upper bits set");
    a_latch_upper: assert property (reg_rvalid_o &&
        $past(reg_addr_i) == 6'h14 |-> reg_rdata_o[7:5] == 3'h0)
        else $error("latch upper bits set");
    a_debug_upper: assert property (reg_rvalid_o &&
        $past(reg_addr_i) == 6'h15 |-> reg_rdata_o[7:2] == 6'h00)
        else $error("debug upper bits set");
    a_kit_bit_zero: assert property (reg_rvalid_o &&
        $past(reg_addr_i) inside {[6'h19:6'h1B]} |-> !reg_rdata_o[0])
        else $error("accessory bit 0 read as one");
    // switch and pin relations
    a_rx_off_audio: assert property (se_rx_disable_o ==
        (left_audio_switch_o | right_audio_switch_o))
        else $error("receiver disable not tied to audio switches");
    a_data2_low: assert property (data2_oe_o |-> !data2_o)
        else $error("data line 2 driven high");
    a_pins_in_mode: assert property (data1_oe_o || data2_oe_o ||
        dm_uart_oe_o |-> $past(accessory_mode_bit_i))
        else $error("pin driven outside accessory mode");
    a_mode_drives_d1: assert property ($past(reset_n_i) &&
        $past(accessory_mode_bit_i) |-> data1_oe_o)
        else $error("data line 1 not driven in accessory mode");
    a_fall_low: assert property (
        fall_enable_o[2:0] == fall_enable_low_i)
        else $error("lower falling enables not passed");
    a_clock_gate: assert property (serial_mode_i ||
        accessory_mode_bit_i |->
        interface_clock_output_en_o == clock_keep_alive_i)
        else $error("clock enable ignores keep-alive");
endmodule

bind pia_regs pia_regs_chk pia_regs_chk_inst
(
    .clk_i, .reset_n_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
    .fall_enable_low_i, .fall_enable_o, .accessory_mode_bit_i,
    .serial_mode_i, .clock_keep_alive_i, .interface_clock_output_en_o,
    .data1_oe_o, .data2_o, .data2_oe_o, .dm_uart_oe_o,
    .left_audio_switch_o, .right_audio_switch_o, .se_rx_disable_o
);

// File: test/pia_regs_test.sv
`timescale 1ns/1ps
// =====================================================================
// self-checking bench for the register block
// =====================================================================
module pia_regs_test;
    reg        clk_i;
    reg        reset_n_i;
    reg  [4:0] rise_en, lvl, old, fe, ev_or;
    reg  [2:0] fall_lo;
    reg  [1:0] line_st;
    reg        ser, keep, dp, d0, ev_clr;
    wire [5:0] addr;
    wire [7:0] wdata, rdata;
    wire       wr, rd, rvalid, acc;
    wire [4:0] fall_en, irq_ev;
    wire       clk_en, d1, d1_oe, d2, d2_oe, dm, dm_oe;
    wire       id_pd, left_sw, right_sw, se_off;
    integer    failures, samples_checked, i, k;
    reg  [7:0] got, v, m, a, b;
    reg        ok;

    pia_regs pia_regs_inst
    (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .rise_enable_i(rise_en), .fall_enable_low_i(fall_lo),
        .fall_enable_o(fall_en), .accessory_mode_bit_i(acc),
        .serial_mode_i(ser), .clock_keep_alive_i(keep),
        .interface_clock_output_en_o(clk_en),
        .host_disconnect_i(lvl[0]), .vbus_valid_i(lvl[1]),
        .session_ok_level_i(lvl[2]), .session_over_level_i(lvl[3]),
        .id_grounded_level_i(lvl[4]), .line_state_i(line_st),
        .dp_level_i(dp), .data0_i(d0), .data1_o(d1), .data1_oe_o(d1_oe),
        .data2_o(d2), .data2_oe_o(d2_oe), .dm_uart_o(dm),
        .dm_uart_oe_o(dm_oe), .id_pulldown_drive_o(id_pd),
        .left_audio_switch_o(left_sw), .right_audio_switch_o(right_sw),
        .se_rx_disable_o(se_off), .irq_event_o(irq_ev)
    );
    pia_link_model pia_link_model_inst
    (
        .clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
        .wr_o(wr), .wdata_o(wdata), .rd_o(rd), .acc_mode_o(acc)
    );
    // free-running clock
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // gathers event pulses between clears
    always @(posedge clk_i)
        ev_or <= ev_clr ? 5'h00 : (ev_or | irq_ev);
    // counts, verdict, end of run
    task give_verdict;
    begin
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task chk_pin(input [8*8-1:0] what, input [7:0] e, input [7:0] g);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e)
        begin
            failures = failures + 1;
            $display("MISMATCH %0s exp %h got %h", what, e, g);
        end
    end
    endtask
    task chk_reg(input [5:0] ad, input [7:0] e);
    begin
        pia_link_model_inst.rd_reg(ad, got, ok);
        if (ok !== 1'b1)
        begin
            failures = failures + 1;
            give_verdict;
        end
        else
            chk_pin("regread", e, got);
    end
    endtask
    // live levels, vbus and session-over masked when both edge enables are set
    function [7:0] f_live(input [4:0] l, input [4:0] r, input [4:0] f);
        f_live = {3'h0, l & ~(r & f & 5'h0A)};
    endfunction
    // enabled edges between two level sets
    function [7:0] f_edge(input [4:0] o, input [4:0] n, input [4:0] r,
                          input [4:0] f);
        f_edge = {3'h0, (r & n & ~o) | (f & o & ~n)};
    endfunction

    // main sequence
    initial
    begin
        reset_n_i = 1'b0;
        {rise_en, lvl, fall_lo, line_st, ser, keep, dp, d0} = 19'h00000;
        ev_clr = 1'b1;
        failures = 0;
        samples_checked = 0;
        i = $urandom(74629);
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        chk_pin("fall_en", 8'h18, {3'h0, fall_en});
        chk_reg(6'h13, 8'h00);
        chk_reg(6'h16, 8'h00);
        chk_reg(6'h19, 8'h00);
        chk_reg(6'h3F, 8'h00);
        // write, set and clear on scratch then accessory control
        for (k = 0; k < 10; k = k + 1)
        begin
            b = (k < 5) ? 8'h16 : 8'h19;
            v = $urandom;
            m = $urandom;
            // accessory bit 0 is never stored
            a = (k < 5) ? 8'hFF : 8'hFE;
            pia_link_model_inst.wr_reg(b[5:0], v);
            chk_reg(b[5:0] + 6'h1, v & a);
            pia_link_model_inst.wr_reg(b[5:0] + 6'h1, m);
            pia_link_model_inst.wr_reg(b[5:0] + 6'h2, m);
            a = v & ~m & a;
            chk_reg(b[5:0] + 6'h2, a);
        end
        // expected first: id pull-down, left, right, receivers off
        v = {4'h0, a[1], a[4], |a[6:5], |a[6:4]};
        chk_pin("switch", v,
            {1'b0, d1_oe, d2_oe, dm_oe, id_pd, left_sw, right_sw, se_off});
        // live status, event latch, debug and upper falling enables
        for (k = 0; k < 8; k = k + 1)
        begin
            @(posedge clk_i);
            rise_en <= $urandom;
            fall_lo <= $urandom;
            line_st <= $urandom;
            ser <= $urandom;
            keep <= $urandom;
            ev_clr <= 1'b1;
            m = $urandom;
            pia_link_model_inst.wr_reg(6'h10, m);
            pia_link_model_inst.wr_reg(6'h14, 8'hFF);
            // the write above must not reach the latch
            chk_reg(6'h14, 8'h00);
            old = lvl;
            ev_clr <= 1'b0;
            @(posedge clk_i);
            lvl <= $urandom;
            @(posedge clk_i);
            // this read lands in the cycle of the synchronised edge
            chk_reg(6'h14, 8'h00);
            fe = {m[4:3], fall_lo};
            chk_reg(6'h13, f_live(lvl, rise_en, fe));
            chk_reg(6'h14, f_edge(old, lvl, rise_en, fe));
            chk_pin("irq_ev", f_edge(old, lvl, rise_en, fe),
                {3'h0, ev_or});
            chk_reg(6'h14, 8'h00);
            chk_reg(6'h15, {6'h00, line_st});
            chk_reg(6'h10, {3'h0, m[4:3], fall_lo});
            chk_pin("clk_en", {7'h0, ~ser | keep},
                {7'h0, clk_en});
        end
        // uart entry and pin routing
        m = $urandom;
        pia_link_model_inst.enter_uart(8'h0C | (m & 8'h80));
        for (k = 0; k < 4; k = k + 1)
        begin
            @(posedge clk_i);
            dp <= $urandom;
            d0 <= $urandom;
            repeat (5) @(posedge clk_i);
            // float bit may also be left over from the accessory loop
            v = {2'h0, 1'b1, dp, ~(m[7] | a[7]), 1'b0, 1'b1, d0};
            chk_pin("uart", v,
                {2'h0, d1_oe, d1, d2_oe, d2, dm_oe, dm});
            chk_pin("clk_en", {7'h0, keep}, {7'h0, clk_en});
        end
        pia_link_model_inst.wr_reg(6'h1B, 8'h08);
        repeat (4) @(posedge clk_i);
        chk_pin("data1", 8'h01, {7'h0, d1});
        give_verdict;
    end
endmodule
